// file: src/adcseq_defs.vh
// Constants for the converter auto-copy sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH
`define ADCSEQ_ADDR_OFF 16'h0000
`define ADCSEQ_HI_FORCE 8'hFF
`define ADCSEQ_LO_MIN 8'hD0
`define ADCSEQ_LO_MAX 8'hFE
`define ADCSEQ_ONBOARD 16'hFFC8
`define ADCSEQ_DEST_BASE 16'h0708
`define ADCSEQ_RES_W 12
`define ADCSEQ_RES_HI_LSB 12
`define ADCSEQ_CNT_ALL 3'h7
`define ADCSEQ_CNT_ZERO 3'h0
`define ADCSEQ_READ_WAIT 8'h04
`define ADCSEQ_FIFO_DEPTH 8
`define ADCSEQ_FIFO_AW 3
`endif

// file: src/adcseq_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes CLK domain is the sampling domain; first stage feeds only the second.
`timescale 1ns/1ps
module adcseq_sync (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  input wire ce,
  // Level in and out
  input wire d,
  output reg q
);
  reg meta_q;
  // Two stages, first read only by the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // adcseq_sync

// file: src/adcseq_fifo.v
// Synchronous FIFO held in flip-flops, valid/ready on both sides.
// Assumes single clock; a full FIFO drops in_ready so the writer stalls.
`timescale 1ns/1ps
module adcseq_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  input wire ce,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  // Storage entries, written by index
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      localparam [AW-1:0] IDX = gi;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_q[gi] <= {WIDTH{1'b0}};
        end else if (push && (wr_q == IDX)) begin
          mem_q[gi] <= in_data;
        end
      end
    end
  endgenerate
  // Pointers and fill count; wrap at DEPTH
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // adcseq_fifo

// file: src/adcseq_top.v
// Converter auto-copy sequencer: reads one converter board each phase tick
// and writes its two 12-bit results into a pair of memory words.
// Assumes a bus read port with a fixed READ_WAIT-cycle wait and no grant, and a memory write port with ready.
//
// Overview of operation
// - Board address zero disables all copying
// - Upper address byte forced to FF
// - Board at even FFD0..FFFE only
// - On-board converters accepted at FFC8
// - Registers read equal nonzero count setting plus one
// - Each tick copy register, then select next
// - Selection wraps cyclically to first register
// - Count zero cycles all eight registers
// - Each 24-bit register holds two results
// - Channels 1-8 to Y words 0708-070F
// - Channels 9-16 to X words 0708-070F
// - Only one board served by sequencer
`timescale 1ns/1ps
`include "adcseq_defs.vh"
module adcseq_top #(
  parameter ADDR_W = 16,
  parameter DATA_W = 24,
  parameter READ_WAIT = `ADCSEQ_READ_WAIT,
  parameter FIFO_DEPTH = `ADCSEQ_FIFO_DEPTH,
  parameter FIFO_AW = `ADCSEQ_FIFO_AW,
  parameter HAS_ONBOARD = 1
) (
  // Clock, reset, enable
  input wire CLK,
  input wire ARST_N,
  input wire CE,
  // Settings
  input wire [15:0] ADC_BOARD_ADDRESS_SETTING,
  input wire [2:0] ADC_REGISTER_COUNT_SETTING,
  input wire SETTING_WE,
  // Phase tick from the controller's phase clock pin
  input wire PHASE_TICK,
  // Converter board bus read
  output reg BUS_RD,
  output reg [ADDR_W-1:0] BUS_ADDR,
  input wire [DATA_W-1:0] BUS_RDATA,
  // Converter select write to board
  output reg BUS_SEL_WR,
  output reg [2:0] BUS_SEL,
  // Memory write port
  output reg MEM_WR,
  output reg MEM_SPACE_X,
  output reg [15:0] MEM_ADDR,
  output reg [23:0] MEM_WDATA,
  input wire MEM_READY,
  // Status
  output reg [15:0] BOARD_ADDR_EFF,
  output reg ADDR_VALID
);
  // One-hot states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_READ = 4'b0010;
  localparam [3:0] ST_PUSH = 4'b0100;
  localparam [3:0] ST_SEL = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [15:0] addr_q;
  reg [2:0] cnt_q;
  reg [2:0] sel_q;
  reg [2:0] sel_d;
  reg [7:0] wait_q;
  reg [DATA_W-1:0] sample_q;
  reg tick_dly_q;
  reg enabled_q;
  // Writer state, declared here since the buffer's drain gate reads it
  reg half_q;
  reg [11:0] sample_hold_q;
  wire tick_s;
  wire tick_rise;
  wire [2:0] last_sel;
  wire [15:0] addr_forced;
  wire lo_ok;
  wire addr_ok;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire [31:0] fifo_in_data;

  // Tick pin arrives from outside the domain
  adcseq_sync u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .d(PHASE_TICK),
    .q(tick_s)
  );

  // Rising edge of the synchronised tick
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_dly_q <= 1'b0;
    end else if (CE) begin
      tick_dly_q <= tick_s;
    end
  end
  assign tick_rise = tick_s && !tick_dly_q;

  // Upper byte reads back as FF unless the address setting is zero
  assign addr_forced = (ADC_BOARD_ADDRESS_SETTING == `ADCSEQ_ADDR_OFF) ? `ADCSEQ_ADDR_OFF :
    {`ADCSEQ_HI_FORCE, ADC_BOARD_ADDRESS_SETTING[7:0]};
  // Even addresses in the board window only
  assign lo_ok = !addr_forced[0] && (addr_forced[7:0] >= `ADCSEQ_LO_MIN) &&
    (addr_forced[7:0] <= `ADCSEQ_LO_MAX);
  assign addr_ok = lo_ok || ((HAS_ONBOARD != 0) && (addr_forced == `ADCSEQ_ONBOARD));

  // Settings latch; a single board address means a single served board
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_q <= `ADCSEQ_ADDR_OFF;
      cnt_q <= `ADCSEQ_CNT_ZERO;
      enabled_q <= 1'b0;
    end else if (CE && SETTING_WE) begin
      addr_q <= addr_forced;
      cnt_q <= ADC_REGISTER_COUNT_SETTING;
      // Zero address or out-of-window address keeps copying off
      enabled_q <= (addr_forced != `ADCSEQ_ADDR_OFF) && addr_ok;
    end
  end

  // Count zero behaves like seven: all eight registers
  assign last_sel = (cnt_q == `ADCSEQ_CNT_ZERO) ? `ADCSEQ_CNT_ALL : cnt_q;

  // Results are two 12-bit halves, each headed to its own space
  // Register index sits at [26:24], right above the 24-bit sample
  assign fifo_in_data = {5'h00, sel_q, sample_q};

  // Result buffer between bus read and memory write
  adcseq_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .in_valid(state_q == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    // No pop while the X half of the previous entry is still pending
    .out_ready(MEM_READY && !MEM_WR && !half_q),
    .out_data(fifo_out_data)
  );

  // Sequencer next state
  always @* begin
    state_d = state_q;
    sel_d = sel_q;
    case (state_q)
      ST_IDLE: begin
        if (tick_rise && enabled_q) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (wait_q == 8'h00) begin
          state_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // A full buffer stalls the sequencer here
        if (fifo_in_ready) begin
          state_d = ST_SEL;
          sel_d = (sel_q >= last_sel) ? 3'h0 : sel_q + 3'h1;
        end
      end
      ST_SEL: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and board bus strobes
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      sel_q <= 3'h0;
      wait_q <= 8'h00;
      sample_q <= {DATA_W{1'b0}};
      BUS_RD <= 1'b0;
      BUS_ADDR <= {ADDR_W{1'b0}};
      BUS_SEL_WR <= 1'b0;
      BUS_SEL <= 3'h0;
    end else if (CE) begin
      state_q <= state_d;
      sel_q <= sel_d;
      BUS_SEL_WR <= 1'b0;
      if (!enabled_q) begin
        sel_q <= 3'h0;
      end
      if (state_q == ST_IDLE && state_d == ST_READ) begin
        BUS_RD <= 1'b1;
        BUS_ADDR <= addr_q[ADDR_W-1:0];
        wait_q <= READ_WAIT[7:0];
      end else if (state_q == ST_READ) begin
        if (wait_q == 8'h00) begin
          BUS_RD <= 1'b0;
          sample_q <= BUS_RDATA;
        end else begin
          wait_q <= wait_q - 8'h01;
        end
      end
      // Next register selected right after the copy, so it converts before the next tick
      if (state_q == ST_PUSH && state_d == ST_SEL) begin
        BUS_SEL_WR <= 1'b1;
        BUS_SEL <= sel_d;
        BUS_ADDR <= addr_q[ADDR_W-1:0];
      end
    end
  end

  // Memory writer: Y word then X word for each buffered sample
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_WR <= 1'b0;
      MEM_SPACE_X <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 24'h00_0000;
      half_q <= 1'b0;
    end else if (CE) begin
      if (MEM_WR && MEM_READY) begin
        MEM_WR <= 1'b0;
      end else if (!MEM_WR && fifo_out_valid && MEM_READY && !half_q) begin
        MEM_WR <= 1'b1;
        MEM_SPACE_X <= 1'b0;
        MEM_ADDR <= `ADCSEQ_DEST_BASE + {13'h0000, fifo_out_data[26:24]};
        // Low twelve bits carry the result; sign extension left to the consumer
        MEM_WDATA <= {12'h000, fifo_out_data[`ADCSEQ_RES_W-1:0]};
        half_q <= 1'b1;
      end else if (!MEM_WR && half_q) begin
        MEM_WR <= 1'b1;
        MEM_SPACE_X <= 1'b1;
        MEM_WDATA <= {12'h000, sample_hold_q};
        half_q <= 1'b0;
      end
    end
  end

  // Upper half held while the Y word is written, since the entry pops then
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sample_hold_q <= 12'h000;
    end else if (CE && !MEM_WR && fifo_out_valid && MEM_READY && !half_q) begin
      sample_hold_q <= fifo_out_data[`ADCSEQ_RES_HI_LSB+11:`ADCSEQ_RES_HI_LSB];
    end
  end

  // Status outputs; the board is reached only through this sequencer
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BOARD_ADDR_EFF <= 16'h0000;
      ADDR_VALID <= 1'b0;
    end else if (CE) begin
      BOARD_ADDR_EFF <= addr_q;
      ADDR_VALID <= enabled_q;
    end
  end
endmodule // adcseq_top

// file: testbench/adcseq_props.sv
// Port checker for the converter auto-copy sequencer.
// Assumes the default READ_WAIT of 4 and one clock domain.
`timescale 1ns/1ps
module adcseq_props (
  // Clock and reset
  input wire CLK,
  input wire ARST_N,
  // Board bus
  input wire BUS_RD,
  input wire [15:0] BUS_ADDR,
  input wire BUS_SEL_WR,
  input wire [2:0] BUS_SEL,
  // Memory port and status
  input wire MEM_WR,
  input wire MEM_READY,
  input wire [15:0] MEM_ADDR,
  input wire [23:0] MEM_WDATA,
  input wire [15:0] BOARD_ADDR_EFF,
  input wire ADDR_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Relations between bus, memory and status outputs
  property p_off; !ADDR_VALID |-> !BUS_RD; endproperty
  a_off: assert property (p_off) else $error("read while disabled");
  property p_hi; ADDR_VALID |-> BOARD_ADDR_EFF[15:8] == 8'hFF; endproperty
  a_hi: assert property (p_hi) else $error("upper byte not forced");
  property p_pos; ADDR_VALID |-> BOARD_ADDR_EFF == 16'hFFC8 || (!BOARD_ADDR_EFF[0] && BOARD_ADDR_EFF[7:0] >= 8'hD0);
  endproperty
  a_pos: assert property (p_pos) else $error("illegal board position");
  property p_addr; BUS_RD |-> BUS_ADDR == BOARD_ADDR_EFF; endproperty
  a_addr: assert property (p_addr) else $error("read off the served board");
  property p_rdlen; $rose(BUS_RD) |-> BUS_RD [*5] ##1 !BUS_RD; endproperty
  a_rdlen: assert property (p_rdlen) else $error("read length wrong");
  property p_sel; $fell(BUS_RD) |-> ##[1:300] BUS_SEL_WR; endproperty
  a_sel: assert property (p_sel) else $error("next register not selected");
  property p_pulse; BUS_SEL_WR |=> !BUS_SEL_WR; endproperty
  a_pulse: assert property (p_pulse) else $error("select pulse too long");
  property p_hold; MEM_WR && !MEM_READY |=> MEM_WR && $stable(MEM_ADDR) && $stable(MEM_WDATA); endproperty
  a_hold: assert property (p_hold) else $error("write dropped under stall");
  property p_dest; MEM_WR |-> MEM_ADDR[15:3] == 13'h00E1; endproperty
  a_dest: assert property (p_dest) else $error("write outside result words");
  // Main scenarios reached
  c_read: cover property ($fell(BUS_RD));
  c_stall: cover property (MEM_WR && !MEM_READY);
  c_wrap: cover property (BUS_SEL_WR && BUS_SEL == 3'h0);
endmodule // adcseq_props
bind adcseq_top adcseq_props u_props (.CLK, .ARST_N, .BUS_RD, .BUS_ADDR, .BUS_SEL_WR, .BUS_SEL, .MEM_WR,
  .MEM_READY, .MEM_ADDR, .MEM_WDATA, .BOARD_ADDR_EFF, .ADDR_VALID);

// file: testbench/adcseq_board.sv
// Behavioural converter board: eight 24-bit registers, one selected.
// Assumes conversion of a selected register ends before the next tick.
`timescale 1ns/1ps
module adcseq_board (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bus from the sequencer
  input wire rd,
  input wire sel_wr,
  input wire [2:0] sel,
  input wire [191:0] tbl,
  output reg [23:0] rdata
);
  reg [2:0] cur_q;
  reg [23:0] last_q;
  // Selection and last driven value; only the sequencer touches us
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= 3'h0;
      last_q <= 24'h00_0000;
    end else begin
      if (sel_wr) cur_q <= sel;
      if (rd) last_q <= rdata;
    end
  end
  // Released bus inverts, so a late sample cannot pass by luck
  always @* rdata = rd ? tbl[cur_q*24 +: 24] : ~last_q;
endmodule // adcseq_board

// file: testbench/tb_adc_auto_copy_sequencer.sv
// Self-checking bench for the converter auto-copy sequencer.
// Assumes the board model in adcseq_board and a random-stall memory.
`timescale 1ns/1ps
module tb_adc_auto_copy_sequencer;
  reg CLK = 0, ARST_N = 0, CE = 1, SETTING_WE = 0, PHASE_TICK = 0, MEM_READY = 0;
  reg [15:0] ADC_BOARD_ADDRESS_SETTING = 16'h0000;
  reg [2:0] ADC_REGISTER_COUNT_SETTING = 3'h0;
  wire BUS_RD, BUS_SEL_WR, MEM_WR, MEM_SPACE_X, ADDR_VALID;
  wire [15:0] BUS_ADDR, MEM_ADDR, BOARD_ADDR_EFF;
  wire [23:0] BUS_RDATA, MEM_WDATA;
  wire [2:0] BUS_SEL;
  reg [191:0] tbl = 0;
  reg [28:0] expq[$];
  reg [15:0] eff;
  reg w;
  integer errors = 0, samples_checked = 0, i, k, n, r;
  always #5 CLK = ~CLK;
  adcseq_top DUT (.CLK, .ARST_N, .CE, .ADC_BOARD_ADDRESS_SETTING, .ADC_REGISTER_COUNT_SETTING, .SETTING_WE,
    .PHASE_TICK, .BUS_RD, .BUS_ADDR, .BUS_RDATA, .BUS_SEL_WR, .BUS_SEL, .MEM_WR, .MEM_SPACE_X, .MEM_ADDR,
    .MEM_WDATA, .MEM_READY, .BOARD_ADDR_EFF, .ADDR_VALID);
  adcseq_board u_brd (.clk(CLK), .arst_n(ARST_N), .rd(BUS_RD), .sel_wr(BUS_SEL_WR), .sel(BUS_SEL), .tbl,
    .rdata(BUS_RDATA));
  task cyc; begin @(posedge CLK); #1; end endtask
  task chk(input [28:0] got, input [28:0] exp); begin
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task end_of_test; begin
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  // Memory stalls at random to back up the write path
  always @(posedge CLK) MEM_READY <= #1 ($urandom % 2) != 0;
  // Oldest note taken off at each accepted write; none may come unasked
  always @(posedge CLK) if (MEM_WR === 1'b1 && MEM_READY) begin
    if (expq.size() == 0) chk({MEM_SPACE_X, MEM_ADDR, MEM_WDATA[11:0]}, 29'h0);
    else chk({MEM_SPACE_X, MEM_ADDR, MEM_WDATA[11:0]}, expq.pop_front());
  end
  // Reset, configure, tick; predicts each pair of result writes
  task run(input [15:0] a, input [2:0] c, input integer ticks); begin
    ARST_N = 0;
    cyc;
    ARST_N = 1;
    ADC_BOARD_ADDRESS_SETTING = a;
    ADC_REGISTER_COUNT_SETTING = c;
    SETTING_WE = 1;
    cyc;
    SETTING_WE = 0;
    cyc;
    eff = (a == 16'h0000) ? 16'h0000 : {8'hFF, a[7:0]};
    w = eff == 16'hFFC8 || (!eff[0] && eff[7:0] >= 8'hD0);
    chk({ADDR_VALID, BOARD_ADDR_EFF}, {w, eff});
    n = (c == 3'h0) ? 8 : c + 1;
    for (k = 0; k < ticks; k = k + 1) begin
      r = k % n;
      if (w) begin
        expq.push_back({1'b0, 16'h0708 + r[15:0], tbl[r*24 +: 12]});
        expq.push_back({1'b1, 16'h0708 + r[15:0], tbl[r*24+12 +: 12]});
      end
      PHASE_TICK = 1;
      repeat (2) cyc;
      PHASE_TICK = 0;
      repeat (30 + $urandom % 8) cyc;
    end
    for (i = 0; i < 500 && expq.size() > 0; i = i + 1) cyc;
    if (expq.size() > 0) begin
      errors = errors + 1;
      $display("mismatch %0t writes missing", $time);
      end_of_test;
    end
  end endtask
  initial begin
    void'($urandom(74003));
    for (i = 0; i < 8; i = i + 1) tbl[i*24 +: 24] = $urandom;
    repeat (16) @(posedge CLK);
    #1 ARST_N = 1;
    cyc;
    run(16'h00D8, 3'h3, 6);
    run(16'hFFFE, 3'h0, 10);
    run(16'hFFC8, 3'h7, 9);
    run(16'hFFD0, 3'h1, 3);
    run(16'h0000, 3'h2, 3);
    run(16'hFFD3, 3'h2, 3);
    run(16'hFFC0, 3'h2, 3);
    end_of_test;
  end
endmodule // tb_adc_auto_copy_sequencer
